// ===== shared/secr_defs.svh
// constants for the security-register program/read link: opcodes, address fields, timing
// assumes a 50 MHz core clock on both ends and an spi mode-0 style link
// Contract
// - program is opcode, 24-bit address, data bytes
// - one to 256 bytes, only erased locations
// - program accepted only with write-enable latch set
// - host holds select low whole command
// - address selects register one-three and byte
// - set lock bit makes program ignored
// - read is opcode, address, eight dummy clocks
// - device samples input on rising clock
// - output changes on falling edge, msb first
// - read offset increments, wraps inside register
// - writes rejected for power-up delay after start
// - busy reads one while programming, status answered
`ifndef SECR_DEFS_SVH
`define SECR_DEFS_SVH

`define SECR_OP_WREN      8'h06
`define SECR_OP_RDSR      8'h05
`define SECR_OP_PROG      8'h42
`define SECR_OP_READ      8'h48
`define SECR_NREG         3
`define SECR_REG_BYTES    256
`define SECR_ADDR_TOP     8'h00
`define SECR_ADDR_MID     4'h0
`define SECR_SEL_FIRST    4'h1
`define SECR_SEL_LAST     4'h3
`define SECR_DUMMY_BITS   5'h08
`define SECR_ERASED       8'hff
`define SECR_HDR_BITS     12'h020
`define SECR_RD_HDR_BITS  12'h028
`define SECR_BYTE_BITS    12'h008
`define SECR_POLL_BITS    12'h010
`define SECR_ST_BUSY      0
`define SECR_ST_WEL       1
`define SECR_CLK_NS       20
`define SECR_SCLK_NS      160
`define SECR_SCLK_HALF    ((`SECR_SCLK_NS / 2) / `SECR_CLK_NS)
`define SECR_PUW_MIN_MS   1
`define SECR_PUW_MAX_MS   10
`define SECR_PUW_MIN_CYC  ((`SECR_PUW_MIN_MS * 1000000) / `SECR_CLK_NS)
`define SECR_PUW_MAX_CYC  ((`SECR_PUW_MAX_MS * 1000000 + `SECR_CLK_NS - 1) / `SECR_CLK_NS)
`define SECR_PROG_NS      20480
`define SECR_PROG_CYC     ((`SECR_PROG_NS + `SECR_CLK_NS - 1) / `SECR_CLK_NS)

`endif

// ===== shared/secr_pkg.sv
// types for both ends of the security-register link
// assumes secr_defs.svh is on the include path
`include "secr_defs.svh"
package secr_pkg;

    typedef enum logic [2:0] {D_OFF, D_CMD, D_ADDR, D_DUMMY, D_DIN, D_DOUT, D_STAT, D_IGN} secr_dst_t;
    typedef enum logic [1:0] {H_PU, H_IDLE, H_FRAME, H_GAP} secr_hst_t;
    typedef enum logic [1:0] {J_WREN, J_PROG, J_READ, J_POLL} secr_job_t;

    typedef struct packed {
        logic [2:0]   sclk_s;
        logic [2:0]   cs_s;
        logic [2:0]   si_s;
        logic         sclk_v;
        logic         cs_v;
        secr_dst_t    st;
        logic [4:0]   bits;
        logic [31:0]  sh;
        logic [7:0]   op;
        logic [1:0]   rsel;
        logic [7:0]   off;
        logic [7:0]   dout;
        logic         so;
        logic         so_oe_n;
        logic         write_enable_latch;
        logic         busy;
        logic         puw_done;
        logic         got_byte;
        logic [10:0]  pcnt;
        logic [19:0]  puw_cnt;
        logic [255:0] pend;
        logic [767:0] done;
    } secr_dev_st_t;

    typedef struct packed {
        secr_hst_t    st;
        secr_job_t    job;
        logic         load;
        logic [1:0]   div;
        logic         sclk;
        logic         cs_n;
        logic         si;
        logic [31:0]  sh;
        logic [7:0]   rsh;
        logic [11:0]  bitn;
        logic [11:0]  fe;
        logic [18:0]  pu_cnt;
        logic [23:0]  addr;
        logic [8:0]   len;
        logic [7:0]   rdata;
        logic         rvalid;
        logic         take;
        logic         dev_busy;
    } secr_host_st_t;

endpackage

// ===== shared/secr_spi_if.sv
// serial link between the host end and the security-register device end
// so_line resolves the device output: released line reads high
`timescale 1ns/1ns
interface secr_spi_if;
    logic cs_n;
    logic sclk;
    logic si;
    logic so;
    logic so_oe_n;
    logic so_line;

    assign so_line = so_oe_n ? 1'b1 : so;

    modport dev  (input cs_n, sclk, si, output so, so_oe_n);
    modport host (output cs_n, sclk, si, input so_line);
endinterface

// ===== design/secr_dev.sv
// device end: three 256-byte one-time-lockable registers with program, read, write enable
// and status read commands; link pins are asynchronous and are oversampled by the core clock
`timescale 1ns/1ns
`include "secr_defs.svh"
module secr_dev #(
    parameter int P_PUW_CYC = `SECR_PUW_MIN_CYC
) (
    // clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_b,
    // serial link
    secr_spi_if.dev                    spi,
    // lock bits, one per register
    input  wire logic [`SECR_NREG-1:0] i_otp_lock_bits,
    // status
    output logic                       o_busy,
    output logic                       o_write_enable_latch
);
    import secr_pkg::*;

    secr_dev_st_t q;
    secr_dev_st_t d;

    logic [7:0] mem [0:767];
    logic [7:0] pbuf [0:255];
    logic       mem_we;
    logic [9:0] mem_wa;
    logic       pb_we;
    logic [7:0] pb_wa;
    logic [7:0] pb_wd;
    logic [7:0] rd_byte;

    // {ok, index} for a 24-bit address; index 0..2 names register one..three
    function automatic logic [2:0] secr_dec(input logic [23:0] a);
        logic ok;
        ok = (a[23:16] == `SECR_ADDR_TOP) && (a[11:8] == `SECR_ADDR_MID)
             && (a[15:12] >= `SECR_SEL_FIRST) && (a[15:12] <= `SECR_SEL_LAST);
        return {ok, 2'(a[13:12] - 2'h1)};
    endfunction

    // unprogrammed bytes read as erased, so the array itself needs no reset
    assign rd_byte = q.done[{q.rsel, q.off}] ? mem[{q.rsel, q.off}] : `SECR_ERASED;

    always_comb begin
        logic       rise;
        logic       fall;
        logic       cs_up;
        logic       cs_dn;
        logic       si_b;
        logic [7:0] byte_in;
        logic [7:0] cur;
        logic [2:0] dec;
        logic [7:0] w;
        rise    = 1'b0;
        fall    = 1'b0;
        cs_up   = 1'b0;
        cs_dn   = 1'b0;
        si_b    = q.si_s[2];
        byte_in = {q.sh[6:0], q.si_s[2]};
        cur     = q.dout;
        dec     = 3'h0;
        w       = q.pcnt[7:0];
        d       = q;
        mem_we  = 1'b0;
        mem_wa  = {q.rsel, w};
        pb_we   = 1'b0;
        pb_wa   = q.off;
        pb_wd   = byte_in;

        d.sclk_s = {q.sclk_s[1:0], spi.sclk};
        d.cs_s   = {q.cs_s[1:0], spi.cs_n};
        d.si_s   = {q.si_s[1:0], spi.si};
        if (q.sclk_s[2] == q.sclk_s[1] && q.sclk_s[2] != q.sclk_v) begin
            d.sclk_v = q.sclk_s[2];
            rise     = q.sclk_s[2];
            fall     = !q.sclk_s[2];
        end
        if (q.cs_s[2] == q.cs_s[1] && q.cs_s[2] != q.cs_v) begin
            d.cs_v = q.cs_s[2];
            cs_up  = q.cs_s[2];
            cs_dn  = !q.cs_s[2];
        end

        // writes are refused until the power-up delay has run out
        if (!q.puw_done) begin
            d.puw_cnt = q.puw_cnt + 20'h1;
            if (q.puw_cnt == 20'(P_PUW_CYC - 1)) begin
                d.puw_done = 1'b1;
            end
        end

        // self-timed program: walk the buffer once, then hold busy for the rest of the cycle
        if (q.busy) begin
            d.pcnt = q.pcnt + 11'h1;
            if (q.pcnt < 11'(`SECR_REG_BYTES) && q.pend[w] && !q.done[{q.rsel, w}]) begin
                mem_we                = 1'b1;
                d.done[{q.rsel, w}]   = 1'b1;
            end
            if (q.pcnt == 11'(`SECR_PROG_CYC - 1)) begin
                d.busy = 1'b0;
            end
        end

        if (cs_up) begin
            // only a command that stopped on a byte boundary gets programmed
            if (q.st == D_DIN && q.bits == 5'h0 && q.got_byte) begin
                d.busy = 1'b1;
                d.pcnt = 11'h0;
                d.write_enable_latch  = 1'b0;
            end
            d.st      = D_OFF;
            d.so_oe_n = 1'b1;
        end else if (cs_dn) begin
            d.st   = D_CMD;
            d.bits = 5'h0;
        end else if (rise && !q.cs_v) begin
            d.sh   = {q.sh[30:0], si_b};
            d.bits = q.bits + 5'h1;
            case (q.st)
                D_CMD: begin
                    if (q.bits == 5'h7) begin
                        d.op   = byte_in;
                        d.bits = 5'h0;
                        d.st   = D_IGN;
                        case (byte_in)
                            `SECR_OP_WREN: begin
                                if (q.puw_done && !q.busy) begin
                                    d.write_enable_latch = 1'b1;
                                end
                            end
                            `SECR_OP_RDSR: begin
                                d.st = D_STAT;
                            end
                            `SECR_OP_PROG: begin
                                if (q.write_enable_latch && q.puw_done && !q.busy) begin
                                    d.st = D_ADDR;
                                end
                            end
                            `SECR_OP_READ: begin
                                if (!q.busy) begin
                                    d.st = D_ADDR;
                                end
                            end
                            default: begin
                                d.st = D_IGN;
                            end
                        endcase
                    end
                end
                D_ADDR: begin
                    if (q.bits == 5'h17) begin
                        dec    = secr_dec({q.sh[22:0], si_b});
                        d.bits = 5'h0;
                        d.off  = {q.sh[6:0], si_b};
                        d.rsel = dec[1:0];
                        if (!dec[2]) begin
                            d.st = D_IGN;
                        end else if (q.op == `SECR_OP_PROG) begin
                            if (i_otp_lock_bits[dec[1:0]]) begin
                                d.st = D_IGN;
                            end else begin
                                d.st       = D_DIN;
                                d.pend     = '0;
                                d.got_byte = 1'b0;
                            end
                        end else begin
                            d.st = D_DUMMY;
                        end
                    end
                end
                D_DUMMY: begin
                    if (q.bits == `SECR_DUMMY_BITS - 5'h1) begin
                        d.st   = D_DOUT;
                        d.bits = 5'h0;
                    end
                end
                D_DIN: begin
                    if (q.bits == 5'h7) begin
                        // more than 256 bytes wrap and overwrite the buffered bytes
                        pb_we          = 1'b1;
                        d.pend[q.off]  = 1'b1;
                        d.got_byte     = 1'b1;
                        d.off          = q.off + 8'h1;
                        d.bits         = 5'h0;
                    end
                end
                default: begin
                    d.bits = q.bits;
                end
            endcase
        end else if (fall && !q.cs_v && (q.st == D_DOUT || q.st == D_STAT)) begin
            if (q.bits == 5'h0) begin
                cur = (q.st == D_DOUT) ? rd_byte : 8'h0;
                if (q.st == D_STAT) begin
                    cur[`SECR_ST_BUSY] = q.busy;
                    cur[`SECR_ST_WEL]  = q.write_enable_latch;
                end
            end
            d.so      = cur[7];
            d.dout    = {cur[6:0], 1'b0};
            d.so_oe_n = 1'b0;
            d.bits    = q.bits + 5'h1;
            if (q.bits == 5'h7) begin
                d.bits = 5'h0;
                if (q.st == D_DOUT) begin
                    d.off = q.off + 8'h1;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q         <= '0;
            q.sclk_s  <= 3'h0;
            q.cs_s    <= 3'h7;
            q.cs_v    <= 1'b1;
            q.st      <= D_OFF;
            q.so_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // storage has no reset; validity is tracked by the done and pend bits
    always_ff @(posedge i_core_clk) begin
        if (mem_we) begin
            mem[mem_wa] <= pbuf[q.pcnt[7:0]];
        end
        if (pb_we) begin
            pbuf[pb_wa] <= pb_wd;
        end
    end

    assign spi.so               = q.so;
    assign spi.so_oe_n          = q.so_oe_n;
    assign o_busy               = q.busy;
    assign o_write_enable_latch = q.write_enable_latch;
endmodule

// ===== design/secr_host.sv
// host end: waits out power-up, then runs write enable + program + busy polling, or a read
// assumes the device on the other side of secr_spi_if; link clock made here by a divider
`timescale 1ns/1ns
`include "secr_defs.svh"
module secr_host #(
    parameter int P_PUW_CYC = `SECR_PUW_MAX_CYC
) (
    // clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_b,
    // serial link
    secr_spi_if.host        spi,
    // request
    input  wire logic       i_start,
    input  wire logic       i_write,
    input  wire logic [1:0] i_reg_sel,
    input  wire logic [7:0] i_offset,
    input  wire logic [8:0] i_len,
    // write data
    input  wire logic [7:0] i_wdata,
    output logic            o_wdata_take,
    // read data and status
    output logic [7:0]      o_rdata,
    output logic            o_rdata_valid,
    output logic            o_ready
);
    import secr_pkg::*;

    secr_host_st_t q;
    secr_host_st_t d;

    always_comb begin
        logic tick;
        logic [7:0] byte_in;
        tick    = (q.div == 2'(`SECR_SCLK_HALF - 1));
        byte_in = {q.rsh[6:0], spi.so_line};
        d        = q;
        d.div    = tick ? 2'h0 : q.div + 2'h1;
        d.rvalid = 1'b0;
        d.take   = 1'b0;
        case (q.st)
            H_PU: begin
                // no write may go out before the longest power-up delay has passed
                d.pu_cnt = q.pu_cnt + 19'h1;
                if (q.pu_cnt == 19'(P_PUW_CYC - 1)) begin
                    d.st = H_IDLE;
                end
            end
            H_IDLE: begin
                if (i_start) begin
                    d.addr = {`SECR_ADDR_TOP, 2'h0, i_reg_sel, `SECR_ADDR_MID, i_offset};
                    d.len  = i_len;
                    d.job  = i_write ? J_WREN : J_READ;
                    d.st   = H_GAP;
                    d.load = 1'b1;
                end
            end
            H_FRAME: begin
                if (tick && !q.sclk) begin
                    if (q.bitn == q.fe) begin
                        d.cs_n = 1'b1;
                        d.st   = H_GAP;
                    end else begin
                        d.sclk = 1'b1;
                        d.bitn = q.bitn + 12'h1;
                    end
                end else if (tick) begin
                    // the device output moves on the rise slot itself, after its synchroniser and flop,
                    // so the bit is taken just before the next fall, where it has settled
                    d.sclk = 1'b0;
                    d.rsh  = byte_in;
                    if (q.job == J_READ && q.bitn > `SECR_RD_HDR_BITS && q.bitn[2:0] == 3'h0) begin
                        d.rdata  = byte_in;
                        d.rvalid = 1'b1;
                    end
                    if (q.job == J_POLL && q.bitn == `SECR_POLL_BITS) begin
                        d.dev_busy = byte_in[`SECR_ST_BUSY];
                    end
                    if (q.job == J_PROG && q.bitn >= `SECR_HDR_BITS && q.bitn[2:0] == 3'h0 && q.bitn < q.fe) begin
                        d.si   = i_wdata[7];
                        d.sh   = {i_wdata[6:0], 25'h0};
                        d.take = 1'b1;
                    end else begin
                        d.si = q.sh[31];
                        d.sh = {q.sh[30:0], 1'b0};
                    end
                end
            end
            H_GAP: begin
                if (tick) begin
                    d.load = 1'b1;
                    if (!q.load) begin
                        case (q.job)
                            J_WREN: d.job = J_PROG;
                            J_PROG: d.job = J_POLL;
                            J_POLL: d.job = J_POLL;
                            default: d.job = J_READ;
                        endcase
                        if (q.job == J_READ || (q.job == J_POLL && !q.dev_busy)) begin
                            d.st   = H_IDLE;
                            d.load = 1'b0;
                        end
                    end else begin
                        // open the next frame; select stays low until its last bit
                        d.load = 1'b0;
                        d.cs_n = 1'b0;
                        d.bitn = 12'h0;
                        d.st   = H_FRAME;
                        case (q.job)
                            J_WREN: begin
                                d.sh = {`SECR_OP_WREN, 24'h0};
                                d.fe = `SECR_BYTE_BITS;
                            end
                            J_PROG: begin
                                d.sh = {`SECR_OP_PROG, q.addr};
                                d.fe = `SECR_HDR_BITS + {q.len, 3'h0};
                            end
                            J_READ: begin
                                d.sh = {`SECR_OP_READ, q.addr};
                                d.fe = `SECR_RD_HDR_BITS + {q.len, 3'h0};
                            end
                            default: begin
                                d.sh = {`SECR_OP_RDSR, 24'h0};
                                d.fe = `SECR_POLL_BITS;
                            end
                        endcase
                        d.si = d.sh[31];
                        d.sh = {d.sh[30:0], 1'b0};
                    end
                end
            end
            default: begin
                d.st = H_PU;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q      <= '0;
            q.st   <= H_PU;
            q.cs_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign spi.cs_n      = q.cs_n;
    assign spi.sclk      = q.sclk;
    assign spi.si        = q.si;
    assign o_wdata_take  = q.take;
    assign o_rdata       = q.rdata;
    assign o_rdata_valid = q.rvalid;
    assign o_ready       = (q.st == H_IDLE);
endmodule

// ===== test/secr_link_properties.sv
// concurrent checks on the serial link between the host end and the device end
// assumes both ends share i_core_clk and i_rst_b; instantiated beside secr_spi_if
`timescale 1ns/1ns
`include "secr_defs.svh"
module secr_link_properties #(
    parameter int P_PUW_CYC = 20
) (
    // clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rst_b,
    // link signals
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic si,
    input  wire logic so,
    input  wire logic so_oe_n
);
    logic        sclk_q;
    logic        cs_n_q;
    logic [11:0] rise_cnt_q;
    logic [7:0]  op_q;
    logic [7:0]  prev_op_q;
    logic [19:0] pu_cnt_q;

    // counts stay valid on the edge where cs_n is seen rising, so frame-end checks see the whole frame
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sclk_q     <= 1'b0;
            cs_n_q     <= 1'b1;
            rise_cnt_q <= 12'h000;
            op_q       <= 8'h00;
            prev_op_q  <= 8'h00;
            pu_cnt_q   <= 20'h00000;
        end else begin
            sclk_q <= sclk;
            cs_n_q <= cs_n;
            if (pu_cnt_q != 20'hfffff) begin
                pu_cnt_q <= pu_cnt_q + 20'h00001;
            end
            if (cs_n) begin
                rise_cnt_q <= 12'h000;
            end else if (sclk && !sclk_q) begin
                rise_cnt_q <= rise_cnt_q + 12'h001;
                if (rise_cnt_q < 12'h008) begin
                    op_q <= {op_q[6:0], si};
                end
            end
            if (cs_n && !cs_n_q) begin
                prev_op_q <= op_q;
            end
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("link clock high while deselected");
    a_so_release: assert property ($rose(cs_n) |-> ##[0:5] so_oe_n)
        else $error("device output not released after deselect");
    a_so_holds: assert property ($rose(sclk) && !so_oe_n |-> ##1 $stable(so)[*3])
        else $error("device output moved while link clock high");
    a_si_stable: assert property ($rose(sclk) |-> $stable(si) ##1 $stable(si))
        else $error("host data moved around rising link clock");
    a_dummy_count: assert property ($fell(so_oe_n) |->
        (op_q == `SECR_OP_READ && rise_cnt_q == `SECR_RD_HDR_BITS)
        || (op_q == `SECR_OP_RDSR && rise_cnt_q == `SECR_BYTE_BITS))
        else $error("device output began at wrong clock count");
    a_prog_after_wren: assert property ($rose(cs_n) && op_q == `SECR_OP_PROG |-> prev_op_q == `SECR_OP_WREN)
        else $error("program frame not preceded by write enable");
    a_prog_whole_bytes: assert property ($rose(cs_n) && op_q == `SECR_OP_PROG |->
        rise_cnt_q >= 12'h028 && rise_cnt_q[2:0] == 3'h0 && rise_cnt_q <= 12'h820)
        else $error("program frame length not whole data bytes");
    a_pu_wait: assert property ($fell(cs_n) |-> pu_cnt_q >= P_PUW_CYC)
        else $error("frame started before power-up wait");
endmodule

// ===== test/tb_top.sv
// self-checking bench: host end and device end joined by secr_spi_if
// assumes one 50 MHz clock and one active-low reset shared by both ends
`timescale 1ns/1ns
`include "secr_defs.svh"
module tb_top;
    localparam int HOST_PUW = 20;
    localparam int DEV_PUW  = 10;

    logic       i_core_clk;
    logic       i_rst_b;
    logic [2:0] lock_bits;
    logic       start;
    logic       write;
    logic [1:0] reg_sel;
    logic [7:0] offset;
    logic [8:0] length;
    logic [7:0] wdata;
    logic       o_wdata_take;
    logic [7:0] o_rdata;
    logic       o_rdata_valid;
    logic       o_ready;
    logic       o_busy;
    logic       o_write_enable_latch;
    logic [7:0] mem [1:3][0:255];
    int         miscompares;
    int         n_checks;
    int         cyc;
    int         r;

    secr_spi_if link ();

    secr_dev #(.P_PUW_CYC(DEV_PUW)) secr_dev_inst (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .spi(link), .i_otp_lock_bits(lock_bits),
        .o_busy(o_busy), .o_write_enable_latch(o_write_enable_latch));

    secr_host #(.P_PUW_CYC(HOST_PUW)) secr_host_inst (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .spi(link), .i_start(start), .i_write(write),
        .i_reg_sel(reg_sel), .i_offset(offset), .i_len(length), .i_wdata(wdata),
        .o_wdata_take(o_wdata_take), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid), .o_ready(o_ready));

    secr_link_properties #(.P_PUW_CYC(HOST_PUW)) secr_link_properties_inst (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .cs_n(link.cs_n), .sclk(link.sclk),
        .si(link.si), .so(link.so), .so_oe_n(link.so_oe_n));

    task automatic conclude();
        if (miscompares == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk1(input string nm, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
        end
    endtask

    // one host request; writes update the model, reads are compared against it
    task automatic xfer(input logic wr, input logic [1:0] rs, input logic [7:0] off, input logic [8:0] len,
                        input logic [7:0] base);
        logic [7:0] q[$];
        logic [7:0] a;
        logic       busy_seen;
        logic       locked;
        int         k;
        int         wi;
        busy_seen = 1'b0;
        wi = 0;
        for (k = 0; k < 100 && o_ready !== 1'b1; k++) @(negedge i_core_clk);
        @(posedge i_core_clk);
        start   <= 1'b1;
        write   <= wr;
        reg_sel <= rs;
        offset  <= off;
        length  <= len;
        wdata   <= base;
        @(posedge i_core_clk);
        start <= 1'b0;
        for (k = 0; k < 40000; k++) begin
            @(negedge i_core_clk);
            if (o_ready === 1'b1) break;
            if (o_busy === 1'b1) busy_seen = 1'b1;
            if (o_rdata_valid === 1'b1) q.push_back(o_rdata);
            if (o_wdata_take === 1'b1) wi++;
            @(posedge i_core_clk);
            wdata <= base + 8'(wi);
        end
        locked = lock_bits[rs - 2'h1];
        if (wr) begin
            // already programmed bytes keep their value
            for (k = 0; k < int'(len); k++) begin
                a = off + 8'(k);
                if (!locked && mem[rs][a] === 8'hff) mem[rs][a] = base + 8'(k);
            end
            chk1("busy seen", !locked, busy_seen);
            chk1("busy", 1'b0, o_busy);
            chk1("data bytes taken", 1'b1, wi == int'(len));
            chk1("write enable latch", locked, o_write_enable_latch);
        end else begin
            chk1("read count", 1'b1, q.size() == int'(len));
            for (k = 0; k < q.size(); k++) begin
                a = off + 8'(k);
                chk8("read byte", mem[rs][a], q[k]);
            end
        end
    endtask

    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end

    // whole run is about 43000 cycles
    initial begin
        cyc = 0;
        forever begin
            @(posedge i_core_clk);
            cyc++;
            if (cyc == 90000) begin
                miscompares++;
                conclude();
            end
        end
    end

    initial begin
        i_rst_b = 1'b0;
        lock_bits = 3'h0;
        start = 1'b0;
        write = 1'b0;
        reg_sel = 2'h1;
        offset = 8'h00;
        length = 9'h001;
        wdata = 8'h00;
        miscompares = 0;
        n_checks = 0;
        foreach (mem[i, j]) mem[i][j] = 8'hff;
        repeat (6) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        xfer(1'b0, 2'h1, 8'h00, 9'h004, 8'h00);
        xfer(1'b1, 2'h1, 8'hfe, 9'h003, 8'ha5);
        xfer(1'b0, 2'h1, 8'hfd, 9'h005, 8'h00);
        xfer(1'b1, 2'h1, 8'hff, 9'h002, 8'h11);
        xfer(1'b0, 2'h1, 8'hfe, 9'h003, 8'h00);
        for (r = 1; r <= 3; r++) begin
            @(posedge i_core_clk);
            lock_bits <= 3'h1 << (r - 1);
            xfer(1'b1, 2'(r), 8'h40, 9'h001, 8'h3c);
            xfer(1'b0, 2'(r), 8'h40, 9'h001, 8'h00);
        end
        @(posedge i_core_clk);
        lock_bits <= 3'h0;
        xfer(1'b1, 2'h3, 8'h00, 9'h100, 8'h30);
        xfer(1'b0, 2'h3, 8'h80, 9'h100, 8'h00);
        xfer(1'b0, 2'h2, 8'hff, 9'h002, 8'h00);
        conclude();
    end
endmodule
